// file: shared/emb_pkg.sv
package emb_pkg;
	localparam int EMB_W = 16;
	localparam int EMB_BUS_AW = 6;
	localparam logic [5:0] OFF_WAIT_CFG = 6'h00;
	localparam logic [5:0] OFF_ADDR = 6'h04;
	localparam logic [5:0] OFF_WDATA = 6'h08;
	localparam logic [5:0] OFF_CMD = 6'h0c;
	localparam logic [5:0] OFF_RDATA = 6'h10;
	localparam logic [5:0] OFF_STATUS = 6'h14;
	localparam logic [5:0] OFF_SYSCTL2 = 6'h18;
	localparam logic [5:0] OFF_IRQ_STAT = 6'h1c;
	localparam logic [5:0] OFF_IRQ_MASK = 6'h20;
	localparam int WS_LSB = 0;
	localparam int WS_BITS = 3;
	localparam int VIS_BIT = 3;
	localparam int CMD_SPACE_LSB = 0;
	localparam int CMD_WRITE_BIT = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_EXT_EN_BIT = 1;
	localparam int STAT_READY_BIT = 2;
	localparam int SYSCTL2_BOOT_BIT = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ILLEGAL_BIT = 1;
	localparam int IRQ_BITS = 2;
	localparam logic [3:0] WAIT_CFG_RESET = 4'h0;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
	localparam logic [15:0] BOOT_VECTOR = 16'h0000;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		SPACE_PROG = 2'h0,
		SPACE_DATA = 2'h1,
		SPACE_IO = 2'h2
	} emb_space_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ACCESS = 4'h2,
		ST_END = 4'h4,
		ST_SKIP = 4'h8
	} emb_state_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data_out;
		logic data_oe;
		logic program_space_strobe_n;
		logic data_space_strobe_n;
		logic io_space_strobe_n;
		logic access_strobe_n;
		logic read_strobe_n;
		logic write_strobe_n;
		logic read_write_n;
		logic write_read;
		logic ctrl_oe;
		logic visibility_output_enable_n;
	} emb_bus_s;

	typedef struct packed {
		logic ready;
		logic boot_source_select;
		logic ext_interface_enable;
		logic emulation_off_n;
		logic test_reset;
		logic emulation_pin_zero;
	} emb_pins_in_s;
endpackage

// file: logic/emb_bus.sv
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module emb_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

module emb_bus (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [emb_pkg::EMB_BUS_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire emb_pkg::emb_pins_in_s pins_in,
	input wire logic [emb_pkg::EMB_W-1:0] data_in,
	output emb_pkg::emb_bus_s bus_out,
	output logic exec_from_external,
	output logic [emb_pkg::EMB_W-1:0] boot_vector
);
	import emb_pkg::*;

	emb_pins_in_s pins_s;
	logic [EMB_W-1:0] data_s;
	emb_state_e state;
	logic [3:0] wait_state_config;
	logic [EMB_W-1:0] addr_reg;
	logic [EMB_W-1:0] wdata_reg;
	logic [EMB_W-1:0] rdata_reg;
	logic [IRQ_BITS-1:0] irq_status;
	logic [IRQ_BITS-1:0] irq_mask;
	logic [31:0] system_ctrl_status_two;
	logic boot_taken;
	logic [SYNC_STAGES-1:0] boot_wait;
	logic [IRQ_BITS-1:0] next_irq_status;
	logic boot_bit;
	logic [WS_BITS-1:0] wait_cnt;
	logic start_req;
	emb_space_e start_space;
	logic start_write;
	logic ev_done;
	logic ev_illegal;
	logic req;
	logic accept;
	logic [31:0] next_readdata;
	logic stat_read;
	logic float_ctrl;
	logic [WS_BITS-1:0] ws;

	emb_sync #(.W($bits(emb_pins_in_s))) u_sync_pins (
		.clk(clk),
		.resetn(resetn),
		.d(pins_in),
		.q(pins_s)
	);

	emb_sync #(.W(EMB_W)) u_sync_data (
		.clk(clk),
		.resetn(resetn),
		.d(data_in),
		.q(data_s)
	);

	assign ws = wait_state_config[WS_LSB +: WS_BITS];
	assign req = avs_read | avs_write;
	assign accept = req & ~avs_waitrequest;
	assign float_ctrl = ~pins_s.emulation_off_n & ~pins_s.test_reset & pins_s.emulation_pin_zero;

	// The bus slave answers one cycle after the request; a command waits while busy.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if (accept) begin
			avs_waitrequest <= 1'b1;
		end else if (req && !(avs_write && avs_address == OFF_CMD && state != ST_IDLE)) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= next_readdata;
		end
	end

	always_comb begin
		next_readdata = 32'h0000_0000;
		if (avs_read) begin
			case (avs_address)
				OFF_WAIT_CFG: next_readdata = {28'h0000000, wait_state_config};
				OFF_ADDR: next_readdata = {16'h0000, addr_reg};
				OFF_WDATA: next_readdata = {16'h0000, wdata_reg};
				OFF_RDATA: next_readdata = {16'h0000, rdata_reg};
				OFF_STATUS: next_readdata = {29'h00000000, pins_s.ready,
					pins_s.ext_interface_enable, state != ST_IDLE};
				OFF_SYSCTL2: next_readdata = system_ctrl_status_two;
				OFF_IRQ_STAT: next_readdata = {30'h00000000, irq_status};
				OFF_IRQ_MASK: next_readdata = {30'h00000000, irq_mask};
				default: next_readdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wait_state_config <= WAIT_CFG_RESET;
			addr_reg <= 16'h0000;
			wdata_reg <= 16'h0000;
			irq_mask <= IRQ_MASK_RESET;
		end else if (accept && avs_write) begin
			case (avs_address)
				OFF_WAIT_CFG: begin
					if (avs_byteenable[0]) begin
						wait_state_config <= avs_writedata[3:0];
					end
				end
				OFF_ADDR: begin
					if (avs_byteenable[0]) begin
						addr_reg[7:0] <= avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						addr_reg[15:8] <= avs_writedata[15:8];
					end
				end
				OFF_WDATA: begin
					if (avs_byteenable[0]) begin
						wdata_reg[7:0] <= avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						wdata_reg[15:8] <= avs_writedata[15:8];
					end
				end
				OFF_IRQ_MASK: begin
					if (avs_byteenable[0]) begin
						irq_mask <= avs_writedata[IRQ_BITS-1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	assign start_req = accept && avs_write && avs_address == OFF_CMD && avs_byteenable[0];
	assign start_space = emb_space_e'(avs_writedata[CMD_SPACE_LSB +: 2]);
	assign start_write = avs_writedata[CMD_WRITE_BIT];
	assign stat_read = accept && avs_read && avs_address == OFF_IRQ_STAT;

	// A read clears only the bits it reported, so an event landing meanwhile is kept.
	assign next_irq_status = (stat_read ? irq_status & ~avs_readdata[IRQ_BITS-1:0] :
		irq_status) | {ev_illegal, ev_done};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_status <= 2'h0;
			irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq <= |(irq_mask & next_irq_status);
		end
	end

	// The boot pin is caught once the synchroniser holds the pin, not its reset value.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			boot_taken <= 1'b0;
			boot_wait <= '0;
			boot_bit <= 1'b0;
			exec_from_external <= 1'b0;
			boot_vector <= BOOT_VECTOR;
		end else begin
			boot_wait <= {boot_wait[SYNC_STAGES-2:0], 1'b1};
			if (boot_wait[SYNC_STAGES-1] && !boot_taken) begin
				boot_taken <= 1'b1;
				boot_bit <= pins_s.boot_source_select;
				exec_from_external <= pins_s.boot_source_select;
				boot_vector <= BOOT_VECTOR;
			end
		end
	end

	always_comb begin
		system_ctrl_status_two = 32'h0000_0000;
		system_ctrl_status_two[SYSCTL2_BOOT_BIT] = boot_bit;
	end

	// Bus cycle engine; every pin comes straight from a flip-flop.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			wait_cnt <= 3'h0;
			rdata_reg <= 16'h0000;
			ev_done <= 1'b0;
			ev_illegal <= 1'b0;
			bus_out.addr <= 16'h0000;
			bus_out.data_out <= 16'h0000;
			bus_out.data_oe <= 1'b0;
			bus_out.program_space_strobe_n <= 1'b1;
			bus_out.data_space_strobe_n <= 1'b1;
			bus_out.io_space_strobe_n <= 1'b1;
			bus_out.access_strobe_n <= 1'b1;
			bus_out.read_strobe_n <= 1'b1;
			bus_out.write_strobe_n <= 1'b1;
			bus_out.read_write_n <= 1'b1;
			bus_out.write_read <= 1'b0;
			bus_out.ctrl_oe <= 1'b0;
			bus_out.visibility_output_enable_n <= 1'b1;
		end else begin
			ev_done <= 1'b0;
			ev_illegal <= 1'b0;
			bus_out.ctrl_oe <= pins_s.ext_interface_enable & ~float_ctrl;
			case (state)
				ST_IDLE: begin
					if (start_req && !pins_s.ext_interface_enable) begin
						ev_illegal <= start_space == SPACE_DATA;
						state <= ST_SKIP;
					end else if (start_req) begin
						wait_cnt <= ws;
						bus_out.addr <= addr_reg;
						bus_out.access_strobe_n <= 1'b0;
						bus_out.program_space_strobe_n <= start_space != SPACE_PROG;
						bus_out.data_space_strobe_n <= start_space != SPACE_DATA;
						bus_out.io_space_strobe_n <= start_space != SPACE_IO;
						bus_out.read_write_n <= ~start_write;
						bus_out.write_read <= start_write;
						bus_out.read_strobe_n <= start_write;
						bus_out.write_strobe_n <= ~start_write;
						bus_out.data_out <= wdata_reg;
						bus_out.data_oe <= start_write;
						bus_out.visibility_output_enable_n <=
							~(start_write & wait_state_config[VIS_BIT]);
						state <= ST_ACCESS;
					end
				end
				ST_ACCESS: begin
					if (wait_cnt != 3'h0) begin
						wait_cnt <= wait_cnt - 3'h1;
					end else if (ws != 3'h0 && !pins_s.ready) begin
						wait_cnt <= 3'h0;
					end else begin
						rdata_reg <= data_s;
						bus_out.access_strobe_n <= 1'b1;
						bus_out.program_space_strobe_n <= 1'b1;
						bus_out.data_space_strobe_n <= 1'b1;
						bus_out.io_space_strobe_n <= 1'b1;
						bus_out.read_strobe_n <= 1'b1;
						bus_out.write_strobe_n <= 1'b1;
						bus_out.data_oe <= 1'b0;
						bus_out.visibility_output_enable_n <= 1'b1;
						state <= ST_END;
					end
				end
				ST_END: begin
					bus_out.read_write_n <= 1'b1;
					bus_out.write_read <= 1'b0;
					ev_done <= 1'b1;
					state <= ST_IDLE;
				end
				ST_SKIP: begin
					ev_done <= 1'b1;
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// file: sim/emb_mem_model.sv
`timescale 1ns/1ps

module emb_mem_model (
	input wire logic clk,
	input wire emb_pkg::emb_bus_s bus_out,
	input wire logic slow,
	output logic ready,
	output logic [15:0] data_in
);
	import emb_pkg::*;
	logic [15:0] mem [16];
	logic [15:0] last = 16'h0;
	int w = 0;
	always @(posedge clk) begin
		if (!bus_out.write_strobe_n && bus_out.data_oe) begin
			mem[bus_out.addr[3:0]] <= bus_out.data_out;
		end
		w <= bus_out.access_strobe_n ? 0 : w + 1;
		if (!bus_out.read_strobe_n) begin
			last <= data_in;
		end
	end
	// A released bus shows the inverse of its last value.
	assign data_in = !bus_out.read_strobe_n ? mem[bus_out.addr[3:0]] : ~last;
	assign ready = !(slow && !bus_out.access_strobe_n && w < 5);
endmodule

// file: sim/emb_bus_checker.sv
`timescale 1ns/1ps

module emb_bus_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire emb_pkg::emb_pins_in_s pins_in,
	input wire emb_pkg::emb_bus_s bus_out
);
	import emb_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	AST_SPACE_ONE:
		assert property ($onehot0(~{bus_out.program_space_strobe_n, bus_out.data_space_strobe_n,
			bus_out.io_space_strobe_n})) else $error("two space strobes low");
	AST_ACCESS:
		assert property (bus_out.access_strobe_n == (bus_out.program_space_strobe_n &
			bus_out.data_space_strobe_n & bus_out.io_space_strobe_n)) else $error("access strobe");
	AST_WR_DIR:
		assert property (!bus_out.write_strobe_n |-> !bus_out.read_write_n && bus_out.data_oe)
			else $error("write without direction");
	AST_IDLE_DIR:
		assert property (bus_out.access_strobe_n && $past(bus_out.access_strobe_n) |->
			bus_out.read_write_n) else $error("direction not idle");
	AST_INV:
		assert property (bus_out.write_read != bus_out.read_write_n) else $error("qualifiers equal");
	AST_RD:
		assert property (!bus_out.read_strobe_n |-> bus_out.read_write_n && !bus_out.data_oe &&
			!bus_out.access_strobe_n) else $error("read strobe misuse");
	AST_OFF:
		assert property (!pins_in.ext_interface_enable [*4] |-> !bus_out.ctrl_oe &&
			bus_out.access_strobe_n) else $error("disabled bus active");
	AST_FLOAT:
		assert property ((!pins_in.emulation_off_n && !pins_in.test_reset &&
			pins_in.emulation_pin_zero) [*4] |-> !bus_out.ctrl_oe) else $error("no float");
	AST_VIS:
		assert property (!bus_out.visibility_output_enable_n |-> bus_out.data_oe)
			else $error("visibility while not driving");
	AST_STABLE:
		assert property (!bus_out.access_strobe_n && $past(!bus_out.access_strobe_n) |->
			$stable(bus_out.addr) && $stable(bus_out.read_write_n)) else $error("addr moved");
endmodule

bind emb_bus emb_bus_checker i_chk (.clk(clk), .resetn(resetn), .pins_in(pins_in),
	.bus_out(bus_out));

// file: sim/emb_bus_bench.sv
`timescale 1ns/1ps

module emb_bus_bench;
	import emb_pkg::*;
	logic clk = 0, resetn = 0, rd = 0, wr = 0, boot = 1, en = 1, eoff = 1, trst = 0, e0 = 0;
	logic slow = 0, wt, irq, rdy, ext;
	logic [5:0] adr = 0;
	logic [31:0] wd = 0, rdat, q;
	logic [15:0] din, bvec;
	logic [6:0] low;
	emb_bus_s bo;
	int errors = 0, cmp_count = 0, cnt[7];
	always #25 clk = ~clk;
	emb_bus i_dut (.clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wt),
		.irq(irq), .pins_in({rdy, boot, en, eoff, trst, e0}), .data_in(din), .bus_out(bo),
		.exec_from_external(ext), .boot_vector(bvec));
	emb_mem_model i_mem (.clk(clk), .bus_out(bo), .slow(slow), .ready(rdy), .data_in(din));
	assign low = ~{bo.visibility_output_enable_n, bo.write_strobe_n, bo.read_strobe_n,
		bo.io_space_strobe_n, bo.data_space_strobe_n, bo.program_space_strobe_n, bo.access_strobe_n};
	always @(posedge clk) foreach (cnt[i]) cnt[i] <= cnt[i] + int'(low[i]);
	task automatic complete_run;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 100);
		q = rdat;
		rd <= 0;
		wr <= 0;
		@(posedge clk);
		if (n >= 100) begin
			errors++;
			$display("[ERR] %0t bus timeout", $time);
			complete_run();
		end
	endtask
	task automatic rst(input logic b);
		boot <= b;
		resetn <= 0;
		repeat (3) @(posedge clk);
		resetn <= 1;
		repeat (4) @(posedge clk);
	endtask
	task automatic op(input logic [1:0] sp, input logic w, input int len, input logic more,
		input logic vis, input logic [15:0] a, input logic [15:0] d);
		int b[7];
		int l;
		int n;
		b = cnt;
		bus(1, OFF_ADDR, {16'h0, a});
		bus(1, OFF_WDATA, {16'h0, d});
		bus(1, OFF_CMD, {29'h0, w, sp});
		n = 0;
		do begin
			bus(0, OFF_STATUS, 32'h0);
			n++;
		end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 50);
		if (q[STAT_BUSY_BIT] !== 1'b0) begin
			errors++;
			$display("[ERR] %0t busy timeout", $time);
			complete_run();
		end
		repeat (3) @(posedge clk);
		l = cnt[0] - b[0];
		if (more) chk(32'(l > len), 32'h1);
		else chk(32'(l), 32'(len));
		for (int i = 1; i < 4; i++) chk(32'(cnt[i] - b[i]), (i - 1 == sp) ? 32'(l) : 32'h0);
		chk(32'(cnt[4] - b[4]), w ? 32'h0 : 32'(l));
		chk(32'(cnt[5] - b[5]), w ? 32'(l) : 32'h0);
		chk(32'(cnt[6] - b[6]), (w && vis) ? 32'(l) : 32'h0);
		if (!w) begin
			bus(0, OFF_RDATA, 32'h0);
			chk({16'h0, q[15:0]}, {16'h0, d});
		end
	endtask
	task automatic t_boot;
		for (int b = 1; b >= 0; b--) begin
			rst(b[0]);
			chk({31'h0, ext}, 32'(b));
			chk({16'h0, bvec}, 32'h0);
			bus(0, OFF_SYSCTL2, 32'h0);
			chk({31'h0, q[SYSCTL2_BOOT_BIT]}, 32'(b));
			bus(0, OFF_WAIT_CFG, 32'h0);
			chk(q, 32'h0);
			bus(0, 6'h24, 32'h0);
			chk(q, 32'h0);
		end
	endtask
	task automatic t_spaces;
		bus(1, OFF_WAIT_CFG, 32'ha);
		for (int s = 0; s < 3; s++) begin
			op(s[1:0], 1, 3, 0, 1, 16'(16'h8a50 + s), 16'(16'hc3a0 + s));
			op(s[1:0], 0, 3, 0, 1, 16'(16'h8a50 + s), 16'(16'hc3a0 + s));
			chk({16'h0, bo.addr}, 32'(16'h8a50 + s));
		end
	endtask
	task automatic t_ready;
		slow <= 1;
		bus(1, OFF_WAIT_CFG, 32'h0);
		op(1, 1, 1, 0, 0, 16'h0040, 16'h1111);
		bus(1, OFF_WAIT_CFG, 32'h2);
		op(1, 1, 3, 1, 0, 16'h0041, 16'h2222);
		slow <= 0;
	endtask
	task automatic t_irq;
		bus(1, OFF_IRQ_MASK, 32'h3);
		op(2, 1, 3, 0, 0, 16'h0003, 16'h0f0f);
		chk({31'h0, irq}, 32'h1);
		bus(0, OFF_IRQ_STAT, 32'h0);
		chk(q, 32'h1);
		bus(0, OFF_IRQ_STAT, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h0);
		bus(1, OFF_IRQ_MASK, 32'h0);
		op(0, 1, 3, 0, 0, 16'h0004, 16'h00ff);
		chk({31'h0, irq}, 32'h0);
		bus(0, OFF_IRQ_STAT, 32'h0);
	endtask
	task automatic t_off;
		en <= 0;
		repeat (4) @(posedge clk);
		chk({31'h0, bo.ctrl_oe}, 32'h0);
		op(1, 1, 0, 0, 0, 16'h0005, 16'h5555);
		bus(0, OFF_IRQ_STAT, 32'h0);
		chk({31'h0, q[IRQ_ILLEGAL_BIT]}, 32'h1);
		en <= 1;
		repeat (4) @(posedge clk);
	endtask
	task automatic t_float;
		eoff <= 0;
		e0 <= 1;
		repeat (4) @(posedge clk);
		chk({31'h0, bo.ctrl_oe}, 32'h0);
		eoff <= 1;
		e0 <= 0;
		repeat (4) @(posedge clk);
		chk({31'h0, bo.ctrl_oe}, 32'h1);
	endtask
	initial begin
		t_boot();
		t_spaces();
		t_ready();
		t_irq();
		t_off();
		t_float();
		complete_run();
	end
endmodule
